// ===== design/level_detector.sv
// Supply level detector: Wishbone registers, settling and interrupt logic
`timescale 1ns/1ns
module level_detector
   import level_detect_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        belowThreshold,
   output analog_cfg_t      analogCfg,
   output logic             lowSupplyIrq
);

   // ************************************************************
   // State
   // ************************************************************
   logic       detectorOn_q;
   logic       rangeSelect_q;
   logic [2:0] thresholdTrim_q;
   logic       below_q;
   logic       belowPrev_q;
   logic       irqStat_q;
   logic       irqMask_q;
   logic       resultReady;
   logic       wrStrobe;
   logic       rise;

   assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

   // Delay from enable until the result can be trusted
   settle_timer #(
      .CYCLES (SETTLE)
   ) u_timer (
      .clk   (clk),
      .reset (reset),
      .run   (detectorOn_q),
      .done  (resultReady)
   );

   // ************************************************************
   // Control registers
   // ************************************************************
   // Trim and range are stored as written; software must keep them still
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         detectorOn_q    <= 1'b0;
         rangeSelect_q   <= RANGE_RESET;
         thresholdTrim_q <= TRIM_RESET;
      end else if (wrStrobe && wb_adr_i == OFF_CONTROL) begin
         rangeSelect_q   <= wb_dat_i[CTL_RANGE_BIT];
         thresholdTrim_q <= wb_dat_i[CTL_TRIM_LSB +: CTL_TRIM_W];
      end else if (wrStrobe && wb_adr_i == OFF_STATUS) begin
         detectorOn_q <= wb_dat_i[STAT_ON_BIT];
      end
   end

   // Drive the analog front end from flops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         analogCfg <= '0;
      end else begin
         analogCfg.enable        <= detectorOn_q;
         analogCfg.rangeSelect   <= rangeSelect_q;
         analogCfg.thresholdTrim <= thresholdTrim_q;
      end
   end

   // ************************************************************
   // Result sampling and edge detect
   // ************************************************************
   // Comparator output taken as synchronous; a flop keeps edges clean
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         below_q     <= 1'b0;
         belowPrev_q <= 1'b0;
      end else begin
         below_q     <= detectorOn_q ? belowThreshold : 1'b0;
         belowPrev_q <= below_q;
      end
   end

   // Only rising edges while armed count as events
   assign rise = below_q && !belowPrev_q && resultReady && detectorOn_q;

   // ************************************************************
   // Interrupt status and mask
   // ************************************************************
   // Set beats write-one-to-clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqStat_q <= 1'b0;
      end else if (rise) begin
         irqStat_q <= 1'b1;
      end else if (wrStrobe && wb_adr_i == OFF_IRQ_STAT && wb_dat_i[IRQ_LOW_BIT]) begin
         irqStat_q <= 1'b0;
      end
   end

   // Mask defaults closed
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqMask_q <= 1'b0;
      end else if (wrStrobe && wb_adr_i == OFF_IRQ_MASK) begin
         irqMask_q <= wb_dat_i[IRQ_LOW_BIT];
      end
   end

   // Level output, registered for a clean pin
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lowSupplyIrq <= 1'b0;
      end else begin
         lowSupplyIrq <= irqStat_q && irqMask_q;
      end
   end

   // ************************************************************
   // Wishbone answer
   // ************************************************************
   // One wait state ack; unmapped reads return zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h0;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            unique case (wb_adr_i)
               OFF_CONTROL:  wb_dat_o <= {28'h0, rangeSelect_q, thresholdTrim_q};
               OFF_STATUS:   wb_dat_o <= {29'h0, below_q, resultReady, detectorOn_q};
               OFF_IRQ_STAT: wb_dat_o <= {31'h0, irqStat_q};
               OFF_IRQ_MASK: wb_dat_o <= {31'h0, irqMask_q};
               default:      wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

endmodule // level_detector

// ===== design/level_detect_pkg.sv
// Package: register map, field layout and timing of the supply level detector
//
// Summary of operation
// - detector_on 1 enables and starts, 0 disables
// - result_ready sets 2 ms after enabling
// - Interrupt only while ready and enabled
// - Interrupt on each rising edge of below_threshold
// - Status bit 2 shows below_threshold
// - Control: range bit 3, trim 2-0
// - Trim code picks one of eight steps
// - Status: ready bit 1, detector_on bit 0
package level_detect_pkg;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [3:0] OFF_CONTROL   = 4'h0;
   localparam logic [3:0] OFF_STATUS    = 4'h4;
   localparam logic [3:0] OFF_IRQ_STAT  = 4'h8;
   localparam logic [3:0] OFF_IRQ_MASK  = 4'hc;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int CTL_RANGE_BIT  = 3;
   localparam int CTL_TRIM_LSB   = 0;
   localparam int CTL_TRIM_W     = 3;
   localparam int STAT_BELOW_BIT = 2;
   localparam int STAT_READY_BIT = 1;
   localparam int STAT_ON_BIT    = 0;
   localparam int IRQ_LOW_BIT    = 0;
   localparam logic [2:0] TRIM_RESET  = 3'h0;
   localparam logic       RANGE_RESET = 1'b0;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_HZ       = 125_000_000;
   localparam int SETTLE_US    = 2000;
   localparam int SETTLE_CYCLES = (CLK_HZ / 1_000_000) * SETTLE_US;

   // Analog front-end settings carried as one bundle
   typedef struct packed {
      logic       enable;
      logic       rangeSelect;
      logic [2:0] thresholdTrim;
   } analog_cfg_t;

endpackage

// ===== design/settle_timer.sv
// Settling delay counter for the supply level detector
`timescale 1ns/1ns
module settle_timer
   import level_detect_pkg::*;
#(
   parameter int CYCLES = SETTLE_CYCLES
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic run,
   output logic      done
);

   logic [31:0] count_q;

   // Count from enable; restarts whenever run drops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_q <= 32'h0;
         done    <= 1'b0;
      end else if (!run) begin
         count_q <= 32'h0;
         done    <= 1'b0;
      end else if (count_q >= CYCLES - 1) begin
         done <= 1'b1;
      end else begin
         count_q <= count_q + 32'h1;
      end
   end

endmodule // settle_timer

// ===== dv/level_detector_checker.sv
// Checker: bus, settling and interrupt properties of the level detector
`timescale 1ns/1ns
module level_detector_checker
   import level_detect_pkg::*;
#(parameter int SETTLE = SETTLE_CYCLES) (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        belowThreshold,
   input wire analog_cfg_t analogCfg,
   input wire logic        lowSupplyIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   int onCnt_q;
   logic stRd;
   // Cycles since enable, saturating so long runs cannot wrap
   always_ff @(posedge clk or posedge reset) begin
      if (reset) onCnt_q <= 0;
      else if (!analogCfg.enable) onCnt_q <= 0;
      else if (onCnt_q < 1000000) onCnt_q <= onCnt_q + 1;
   end
   assign stRd = wb_ack_o && !wb_we_i && wb_adr_i == OFF_STATUS;
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("idle data");
   AST_RESERVED: assert property (wb_ack_o |-> wb_dat_o[31:4] == 28'h0 &&
      (!stRd || !wb_dat_o[3])) else $error("reserved bits");
   AST_CFG: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFF_CONTROL && wb_sel_i[0]
      |=> ##1 analogCfg[3:0] == $past(wb_dat_i[3:0], 2)) else $error("control copy");
   AST_ENABLE: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFF_STATUS && wb_sel_i[0]
      |=> ##1 analogCfg.enable == $past(wb_dat_i[0], 2)) else $error("enable copy");
   AST_NOT_READY: assert property (stRd && onCnt_q < SETTLE - 4 |-> !wb_dat_o[1])
      else $error("ready early");
   AST_READY: assert property (stRd && onCnt_q > SETTLE + 3 |-> wb_dat_o[1])
      else $error("ready late");
   AST_BELOW: assert property (stRd && analogCfg.enable && $stable(belowThreshold) &&
      $past(belowThreshold, 2) == belowThreshold |-> wb_dat_o[2] == belowThreshold)
      else $error("below bit");
   AST_IRQ_SETTLED: assert property ($rose(lowSupplyIrq) |-> onCnt_q >= SETTLE - 3 ||
      $past(wb_we_i, 2)) else $error("irq before ready");
   AST_IRQ_EDGE: assert property ($rose(lowSupplyIrq) |-> $past(wb_we_i, 2) ||
      $past(belowThreshold, 2) || $past(belowThreshold, 3) || $past(belowThreshold, 4))
      else $error("irq without edge");
   COV_IRQ: cover property ($rose(lowSupplyIrq));
   COV_READY: cover property (stRd && wb_dat_o[1]);
   COV_CTRL: cover property (wb_ack_o && wb_we_i && wb_adr_i == OFF_CONTROL);
endmodule // level_detector_checker
bind level_detector level_detector_checker #(.SETTLE(SETTLE)) i_level_detector_checker (
   .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .belowThreshold(belowThreshold), .analogCfg(analogCfg),
   .lowSupplyIrq(lowSupplyIrq));

// ===== dv/level_detector_bench.sv
// Testbench: register, settling and interrupt tests of the level detector
`timescale 1ns/1ns
module level_detector_bench;
   import level_detect_pkg::*;
   localparam int ST = 20; // Short settling keeps the run brief
   logic        clk, reset, cyc, stb, we, below, irq, ack;
   logic [3:0]  adr, sel;
   logic [31:0] dat, rdat;
   analog_cfg_t cfg;
   int          errors, n_compared;
   level_detector #(.SETTLE(ST)) i_level_detector (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .belowThreshold(below), .analogCfg(cfg),
      .lowSupplyIrq(irq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic cycle; the request stands until ack is sampled
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) errors++;
      q = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk("register", e, q);
   endtask
   // Raise the comparator, read the sticky interrupt bit, then drop it again
   task automatic bump(input logic [31:0] e);
      @(posedge clk) below <= 1'b1;
      repeat (4) @(posedge clk);
      rd(4'h8, e);
      @(posedge clk) below <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic summarize();
      if (errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      summarize();
   end
   initial begin
      {cyc, stb, we, below, adr, dat, reset} = {4'h0, 4'h0, 32'h0, 1'b1};
      sel = 4'hf;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0);
      rd(4'h2, 32'h0);
      // Settings are only changed while the detector is off
      for (int i = 0; i < 16; i++) begin
         wr(4'h0, {24'h0, 4'(i), 4'(i)});
         rd(4'h0, 32'(i));
         chk("cfg", 32'(i), {28'h0, cfg.rangeSelect, cfg.thresholdTrim});
      end
      // A write with lane 0 off must leave the control word alone
      @(posedge clk) sel <= 4'h0;
      wr(4'h0, 32'h0);
      @(posedge clk) sel <= 4'hf;
      rd(4'h0, 32'hf);
      wr(4'hc, 32'h1);
      wr(4'h4, 32'hff);
      rd(4'h4, 32'h1);
      chk("enable", 32'h1, {31'h0, cfg.enable});
      repeat (ST) @(posedge clk);
      rd(4'h4, 32'h3);
      @(posedge clk) below <= 1'b1;
      repeat (4) @(posedge clk);
      rd(4'h4, 32'h7);
      rd(4'h8, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      wr(4'h8, 32'h1);
      rd(4'h8, 32'h0);
      @(posedge clk) below <= 1'b0;
      repeat (4) @(posedge clk);
      rd(4'h8, 32'h0);
      rd(4'h4, 32'h3);
      wr(4'hc, 32'h0);
      bump(32'h1);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(4'hc, 32'h1);
      rd(4'hc, 32'h1);
      chk("unmasked irq", 32'h1, {31'h0, irq});
      wr(4'h8, 32'h1);
      wr(4'h4, 32'h0);
      rd(4'h4, 32'h0);
      chk("disable", 32'h0, {31'h0, cfg.enable});
      bump(32'h0);
      wr(4'h4, 32'h1);
      rd(4'h4, 32'h1);
      bump(32'h0);
      summarize();
   end
endmodule // level_detector_bench
